// file: hdl/tca_top.sv
// Thermal sensor readout: registers, conversion results and over-limit alarm
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/10ps
`include "tca_defs.svh"
module tca_top
    import tca_pkg::*;
#(
    parameter int unsigned CONV_CYCLES = `TCA_CONV_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [11:0] sense_code,
    output logic over_limit_alarm_o,
    output logic over_limit_alarm_oe,
    output logic shutdown_o,
    output logic ready_o
);
    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    // Assert at once, release only after two clean edges
    // Everything else sees rst_n_ff, never the raw pin
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    tca_top_st_t st_ff;
    tca_top_st_t nxt_st;
    // Helpers shared by the decode and next-state logic
    logic conv_valid;
    logic [11:0] conv_code;
    logic [15:0] res_mask;
    logic [15:0] new_temp;
    logic [2:0] flt_limit;
    logic hot;
    logic cold;
    logic [2:0] idx;
    logic req;
    logic rd_done;
    logic wr_done;
    logic int_mode;
    logic alarm_clear;
    logic [2:0] cnt_inc;
    logic [2:0] wr_idx;

    // ----------------------------------------------------------------
    // Conversion timer
    // ----------------------------------------------------------------
    // Shutdown comes straight from the register, so the timer parks at once
    tca_conv #(
        .CONV_CYCLES(CONV_CYCLES)
    ) u_conv (
        .clk(clk),
        .rst_n(rst_n_ff),
        .shutdown(st_ff.conf[`TCA_CONF_SD]),
        .sense_code(sense_code),
        .conv_valid(conv_valid),
        .conv_code(conv_code)
    );

    // ----------------------------------------------------------------
    // Resolution and fault tolerance decode
    // ----------------------------------------------------------------
    // Mask keeps 9..12 top bits; 0.5 C down to 0.0625 C per step
    // Only four codes exist, so no default is needed
    always_comb begin
        unique case (st_ff.conf[`TCA_CONF_RES_HI:`TCA_CONF_RES_LO])
            2'h0: res_mask = `TCA_MASK_9;
            2'h1: res_mask = `TCA_MASK_10;
            2'h2: res_mask = `TCA_MASK_11;
            2'h3: res_mask = `TCA_MASK_12;
        endcase
    end

    always_comb begin
        unique case (st_ff.conf[`TCA_CONF_FLT_HI:`TCA_CONF_FLT_LO])
            2'h0: flt_limit = `TCA_FLT_1;
            2'h1: flt_limit = `TCA_FLT_2;
            2'h2: flt_limit = `TCA_FLT_4;
            2'h3: flt_limit = `TCA_FLT_6;
        endcase
    end

    // Sign stays in bit 15; the four lowest bits are always zero
    // Resolution is applied as the value lands, not when it is read
    assign new_temp = {conv_code, 4'h0} & res_mask;

    // ----------------------------------------------------------------
    // Limit comparators, one per trip point
    // ----------------------------------------------------------------
    tca_cmp #(
        .W(16)
    ) u_cmp_upper (
        .value(new_temp),
        .limit(st_ff.upper_trip_limit),
        .mask(res_mask),
        .above(hot),
        .below()
    );

    tca_cmp #(
        .W(16)
    ) u_cmp_lower (
        .value(new_temp),
        .limit(st_ff.hyst),
        .mask(res_mask),
        .above(),
        .below(cold)
    );

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // One wait state: the request is answered the edge after it appears
    // Indices 7 and up read as zero and swallow writes
    assign idx = avs_address[4:2];
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~st_ff.ack;
    assign rd_done = avs_read & st_ff.ack;
    assign wr_done = avs_write & st_ff.ack;
    assign int_mode = st_ff.conf[`TCA_CONF_MODE];
    // The pointed window is written through to the selected register
    assign wr_idx = (idx == `TCA_IDX_DATA) ? {1'b0, st_ff.ptr} : idx;

    // Any read of a sensor register, or shutdown, clears an interrupt alarm
    assign alarm_clear = int_mode & ((rd_done & (idx <= `TCA_IDX_DATA) & (idx != `TCA_IDX_PTR)
                         & (idx != `TCA_IDX_STAT)) | st_ff.conf[`TCA_CONF_SD]);
    assign cnt_inc = st_ff.flt_cnt + 3'h1;

    // ----------------------------------------------------------------
    // Byte-lane merge for 16-bit registers
    // ----------------------------------------------------------------
    function automatic logic [15:0] tca_merge(input logic [15:0] old_v,
                                              input logic [31:0] wd,
                                              input logic [3:0] be);
        logic [15:0] r;
        r = old_v;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : tca_merge

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    function automatic logic [31:0] tca_rd(input tca_top_st_t s, input logic [2:0] i);
        logic [31:0] r;
        r = 32'h00000000;
        unique case (i)
            `TCA_IDX_TEMP: r = {16'h0000, s.temp};
            `TCA_IDX_CONF: r = {24'h000000, s.conf};
            `TCA_IDX_HYST: r = {16'h0000, s.hyst};
            `TCA_IDX_TOS: r = {16'h0000, s.upper_trip_limit};
            `TCA_IDX_PTR: r = {30'h00000000, s.ptr};
            `TCA_IDX_STAT: r = {24'h000000, s.ready, s.alarm_st, s.flt_cnt, 2'h0};
            default: r = 32'h00000000;
        endcase
        return r;
    endfunction : tca_rd

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = req & ~st_ff.ack;

        // Read data captured in the wait cycle, stands until next read
        // Capturing early keeps readdata off the combinational path
        if (avs_read & ~st_ff.ack) begin
            if (idx == `TCA_IDX_DATA) begin
                nxt_st.rdata = tca_rd(st_ff, {1'b0, st_ff.ptr});
            end else begin
                nxt_st.rdata = tca_rd(st_ff, idx);
            end
        end

        // Register writes land at the edge where waitrequest is low
        if (wr_done) begin
            unique case (wr_idx)
                `TCA_IDX_CONF: begin
                    if (avs_byteenable[0]) begin
                        nxt_st.conf = {1'b0, avs_writedata[6:0]};
                    end
                end
                // Four lowest limit bits are hardwired to zero
                // Lanes merge first, then the low nibble is masked off
                `TCA_IDX_HYST: nxt_st.hyst = tca_merge(st_ff.hyst, avs_writedata,
                                                       avs_byteenable) & 16'hFFF0;
                `TCA_IDX_TOS: nxt_st.upper_trip_limit = tca_merge(st_ff.upper_trip_limit, avs_writedata,
                                                     avs_byteenable) & 16'hFFF0;
                // A pointer write with any of bits 7:2 set is dropped
                `TCA_IDX_PTR: begin
                    if (avs_byteenable[0] && (avs_writedata[7:2] == 6'h00)) begin
                        nxt_st.ptr = avs_writedata[1:0];
                    end
                end
                default: nxt_st = nxt_st;
            endcase
        end

        // Fresh conversion reaches the readable register
        if (conv_valid) begin
            nxt_st.temp = new_temp;
            nxt_st.ready = 1'b1;
        end

        // Alarm sequencing, evaluated on every conversion, bus or not
        // Comparator mode uses only wait-hot and hot; interrupt mode
        // walks all four states and is cleared by reads or shutdown
        unique case (st_ff.alarm_st)
            TCA_WAIT_HOT: begin
                if (conv_valid) begin
                    if (hot) begin
                        if (cnt_inc >= flt_limit) begin
                            nxt_st.alarm_st = TCA_HOT;
                            nxt_st.flt_cnt = 3'h0;
                        end else begin
                            nxt_st.flt_cnt = cnt_inc;
                        end
                    end else begin
                        nxt_st.flt_cnt = 3'h0;
                    end
                end
            end
            TCA_HOT: begin
                if (!int_mode) begin
                    if (conv_valid && cold) begin
                        nxt_st.alarm_st = TCA_WAIT_HOT;
                    end
                end else if (alarm_clear) begin
                    nxt_st.alarm_st = TCA_WAIT_COLD;
                end
            end
            TCA_WAIT_COLD: begin
                if (!int_mode) begin
                    nxt_st.alarm_st = TCA_WAIT_HOT;
                    nxt_st.flt_cnt = 3'h0;
                end else if (conv_valid) begin
                    if (cold) begin
                        if (cnt_inc >= flt_limit) begin
                            nxt_st.alarm_st = TCA_COLD;
                            nxt_st.flt_cnt = 3'h0;
                        end else begin
                            nxt_st.flt_cnt = cnt_inc;
                        end
                    end else begin
                        nxt_st.flt_cnt = 3'h0;
                    end
                end
            end
            TCA_COLD: begin
                if (!int_mode || alarm_clear) begin
                    nxt_st.alarm_st = TCA_WAIT_HOT;
                end
            end
        endcase

        // Open-drain: low drive when active-low alarm, release when active-high
        // Taken from the next state so the pin moves with the state itself
        nxt_st.alarm_oe = ((nxt_st.alarm_st == TCA_HOT) || (nxt_st.alarm_st == TCA_COLD))
                          ^ nxt_st.conf[`TCA_CONF_POL];
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Only the synchronised reset clears state, so release is clean
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            st_ff.conf <= `TCA_CONF_RST;
            st_ff.upper_trip_limit <= `TCA_TOS_RST;
            st_ff.hyst <= `TCA_HYST_RST;
            st_ff.temp <= `TCA_TEMP_RST;
            st_ff.ptr <= `TCA_PTR_RST;
            st_ff.ack <= 1'b0;
            st_ff.rdata <= 32'h00000000;
            st_ff.alarm_st <= TCA_WAIT_HOT;
            st_ff.flt_cnt <= 3'h0;
            st_ff.alarm_oe <= 1'b0;
            st_ff.ready <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign avs_readdata = st_ff.rdata;
    // Data side of the open drain is tied low; oe alone moves the pin
    assign over_limit_alarm_o = 1'b0;
    assign over_limit_alarm_oe = st_ff.alarm_oe;
    assign shutdown_o = st_ff.conf[`TCA_CONF_SD];
    // Ready is sticky once the first conversion has landed
    assign ready_o = st_ff.ready;

endmodule : tca_top

// file: include/tca_defs.svh
// Register offsets, field positions, reset values and timing counts of the thermal alarm block
`ifndef TCA_DEFS_SVH
`define TCA_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define TCA_IDX_TEMP 3'h0
`define TCA_IDX_CONF 3'h1
`define TCA_IDX_HYST 3'h2
`define TCA_IDX_TOS 3'h3
`define TCA_IDX_PTR 3'h4
`define TCA_IDX_STAT 3'h5
`define TCA_IDX_DATA 3'h6

// ----------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------
`define TCA_CONF_SD 0
`define TCA_CONF_MODE 1
`define TCA_CONF_POL 2
`define TCA_CONF_FLT_LO 3
`define TCA_CONF_FLT_HI 4
`define TCA_CONF_RES_LO 5
`define TCA_CONF_RES_HI 6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TCA_CONF_RST 8'h00
`define TCA_TOS_RST 16'h5000
`define TCA_HYST_RST 16'h4B00
`define TCA_TEMP_RST 16'h0000
`define TCA_PTR_RST 2'h0

// ----------------------------------------------------------------
// Resolution masks and fault tolerance counts
// ----------------------------------------------------------------
`define TCA_MASK_9 16'hFF80
`define TCA_MASK_10 16'hFFC0
`define TCA_MASK_11 16'hFFE0
`define TCA_MASK_12 16'hFFF0
`define TCA_FLT_1 3'h1
`define TCA_FLT_2 3'h2
`define TCA_FLT_4 3'h4
`define TCA_FLT_6 3'h6

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TCA_CLK_KHZ 50000
`define TCA_CONV_TIME_MS 90
`define TCA_POR_TIME_MS 500
`define TCA_CONV_CYCLES (`TCA_CONV_TIME_MS * `TCA_CLK_KHZ)
`define TCA_POR_CYCLES (`TCA_POR_TIME_MS * `TCA_CLK_KHZ)

`endif

// file: include/tca_pkg.sv
// Types shared by the thermal alarm block
package tca_pkg;

    // ----------------------------------------------------------------
    // Alarm states, Gray coded around the interrupt-mode cycle
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TCA_WAIT_HOT = 2'h0,
        TCA_HOT = 2'h1,
        TCA_WAIT_COLD = 2'h3,
        TCA_COLD = 2'h2
    } tca_alarm_st_t;

    // ----------------------------------------------------------------
    // State of the register and alarm logic
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] conf;
        logic [15:0] upper_trip_limit;
        logic [15:0] hyst;
        logic [15:0] temp;
        logic [1:0] ptr;
        logic ack;
        logic [31:0] rdata;
        tca_alarm_st_t alarm_st;
        logic [2:0] flt_cnt;
        logic alarm_oe;
        logic ready;
    } tca_top_st_t;

    // ----------------------------------------------------------------
    // State of the conversion timer
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [22:0] cnt;
        logic valid;
        logic [11:0] code;
    } tca_conv_st_t;

endpackage : tca_pkg

// file: hdl/tca_cmp.sv
// Signed compare of a conversion against one trip limit at the active resolution
`timescale 1ns/10ps
module tca_cmp
    import tca_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic [W-1:0] value,
    input wire logic [W-1:0] limit,
    input wire logic [W-1:0] mask,
    output logic above,
    output logic below
);
    // ----------------------------------------------------------------
    // Compare
    // ----------------------------------------------------------------
    // Limit bits below the resolution are ignored, as the conversion has none
    logic signed [W-1:0] v_m;
    logic signed [W-1:0] l_m;
    assign v_m = value & mask;
    assign l_m = limit & mask;
    assign above = v_m > l_m;
    assign below = v_m < l_m;
endmodule : tca_cmp

// file: hdl/tca_conv.sv
// Conversion timer: samples the modulator result once per conversion period
`timescale 1ns/10ps
`include "tca_defs.svh"
module tca_conv
    import tca_pkg::*;
#(
    parameter int unsigned CONV_CYCLES = `TCA_CONV_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic shutdown,
    input wire logic [11:0] sense_code,
    output logic conv_valid,
    output logic [11:0] conv_code
);
    tca_conv_st_t st_ff;
    tca_conv_st_t nxt_st;

    // ----------------------------------------------------------------
    // Period counter
    // ----------------------------------------------------------------
    // Shutdown parks the counter so a restart gives a full fresh period
    always_comb begin
        nxt_st = st_ff;
        nxt_st.valid = 1'b0;
        if (shutdown) begin
            nxt_st.cnt = 23'h000000;
        end else if (st_ff.cnt == 23'(CONV_CYCLES - 1)) begin
            nxt_st.cnt = 23'h000000;
            nxt_st.valid = 1'b1;
            nxt_st.code = sense_code;
        end else begin
            nxt_st.cnt = st_ff.cnt + 23'h000001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign conv_valid = st_ff.valid;
    assign conv_code = st_ff.code;
endmodule : tca_conv

// file: verif/tca_top_chk_sva.sv
// Port assertions for the thermal alarm block
`timescale 1ns/10ps
module tca_top_chk #(
    parameter int unsigned CONV_CYCLES = 20
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic over_limit_alarm_o,
    input wire logic over_limit_alarm_oe,
    input wire logic shutdown_o,
    input wire logic ready_o
);
    // ----
    // Bounds and helpers
    // ----
    // Two sync flops plus one conversion, with slack for output registers
    localparam int RDY_MAX = CONV_CYCLES + 8;
    logic req;
    assign req = avs_read | avs_write;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Open drain: the data side never drives high
    chk_od_low: assert property (
        over_limit_alarm_o == 1'b0) else $error("alarm data not low");
    chk_wait_first: assert property (
        req && !$past(req) |-> avs_waitrequest) else $error("no first wait state");
    chk_wait_one: assert property (
        req && avs_waitrequest |=> !avs_waitrequest) else $error("wait over one cycle");
    chk_idle_nowait: assert property (
        !req |-> !avs_waitrequest) else $error("wait while idle");
    chk_rd_stable: assert property (
        !avs_read |=> $stable(avs_readdata)) else $error("read data moved");
    // Shutdown output only moves on an accepted write
    chk_sd_cause: assert property (
        $changed(shutdown_o) |-> $past(avs_write && !avs_waitrequest))
        else $error("shutdown moved without write");
    // Cycles spent not ready since release; a counter keeps long periods cheap
    logic [31:0] rdy_cnt_ff;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdy_cnt_ff <= 32'h00000000;
        end else if (!ready_o) begin
            rdy_cnt_ff <= rdy_cnt_ff + 32'h00000001;
        end
    end
    chk_ready_time: assert property (
        rdy_cnt_ff <= 32'(RDY_MAX)) else $error("not ready in time");
    chk_ready_hold: assert property (
        ready_o |=> ready_o) else $error("ready dropped");
    cover property (over_limit_alarm_oe);
    cover property ($rose(shutdown_o));
    cover property (avs_read && !avs_waitrequest);
endmodule : tca_top_chk

bind tca_top tca_top_chk #(.CONV_CYCLES(CONV_CYCLES)) i_chk (
    .clk(clk), .resetn(resetn), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .over_limit_alarm_o(over_limit_alarm_o), .over_limit_alarm_oe(over_limit_alarm_oe),
    .shutdown_o(shutdown_o), .ready_o(ready_o));

// file: verif/tca_sense_model.sv
// Sensor front end and alarm pin pull-up seen by the block
`timescale 1ns/10ps
module tca_sense_model (
    input wire logic [11:0] temp_code,
    input wire logic alarm_o,
    input wire logic alarm_oe,
    output logic [11:0] sense_code,
    output logic alarm_pin
);
    // Modulator result follows the set temperature
    assign sense_code = temp_code;
    // Pull-up wins whenever the drain is released
    assign alarm_pin = alarm_oe ? alarm_o : 1'b1;
endmodule : tca_sense_model

// file: verif/tca_top_bench.sv
// Self-checking bench for the thermal alarm block
`timescale 1ns/10ps
`include "tca_defs.svh"
module tca_top_bench
    import tca_pkg::*;
;
    localparam int C = 20;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [11:0] temp_code = 12'h000;
    logic [11:0] sense_code;
    logic alarm_o, alarm_oe, alarm_pin, shutdown_o, ready_o;
    logic [31:0] rd;
    logic [15:0] masks [4] = '{16'hFF80, 16'hFFC0, 16'hFFE0, 16'hFFF0};
    logic [11:0] codes [2] = '{12'h3FF, 12'hEB9};
    int ft [4] = '{1, 2, 4, 6};
    int err_total = 0;
    int check_count = 0;
    int n;
    tca_top #(.CONV_CYCLES(C)) i_dut (
        .clk(clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sense_code(sense_code),
        .over_limit_alarm_o(alarm_o), .over_limit_alarm_oe(alarm_oe),
        .shutdown_o(shutdown_o), .ready_o(ready_o));
    tca_sense_model i_model (.temp_code(temp_code), .alarm_o(alarm_o),
        .alarm_oe(alarm_oe), .sense_code(sense_code), .alarm_pin(alarm_pin));
    initial begin
        forever #10 clk = ~clk;
    end
    // ----
    // Shared tasks
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    // Request held until waitrequest is seen low at an edge; idle edge first
    task automatic xfer(input logic w, input logic [2:0] i, input logic [31:0] d,
                        input logic [3:0] be);
        int k;
        k = 0;
        @(posedge clk);
        avs_address <= {i, 2'b00};
        avs_read <= ~w;
        avs_write <= w;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            err_total++;
            finish_test();
        end
    endtask : xfer
    task automatic wr(input logic [2:0] i, input logic [31:0] d);
        xfer(1'b1, i, d, 4'hF);
    endtask : wr
    task automatic rdchk(input logic [2:0] i, input logic [31:0] exp);
        xfer(1'b0, i, 32'h0, 4'hF);
        check(rd, exp);
    endtask : rdchk
    task automatic wait_clk(input int c);
        repeat (c) @(posedge clk);
    endtask : wait_clk
    // ----
    // Main sequence
    // ----
    initial begin
        wait_clk(5);
        resetn <= 1'b1;
        wait_clk(3);
        rdchk(`TCA_IDX_TEMP, 32'h0);
        rdchk(`TCA_IDX_CONF, 32'h0);
        rdchk(`TCA_IDX_TOS, 32'h5000);
        rdchk(`TCA_IDX_HYST, 32'h4B00);
        rdchk(`TCA_IDX_PTR, 32'h0);
        rdchk(3'h7, 32'h0);
        check(32'(alarm_pin), 32'h1);
        $display("reset values done");
        // Every resolution code with a positive and a negative reading
        for (int s = 0; s < 2; s++) begin
            temp_code <= codes[s];
            for (int r = 0; r < 4; r++) begin
                wr(`TCA_IDX_CONF, 32'(r << 5));
                wait_clk(2 * C);
                rdchk(`TCA_IDX_DATA, {16'h0, {codes[s], 4'h0} & masks[r]});
            end
        end
        check(32'(ready_o), 32'h1);
        $display("resolution done");
        // Shutdown freezes the reading; clearing it resumes conversions
        wr(`TCA_IDX_CONF, 32'h61);
        temp_code <= 12'h123;
        wait_clk(3 * C);
        check(32'(shutdown_o), 32'h1);
        rdchk(`TCA_IDX_TEMP, 32'hEB90);
        wr(`TCA_IDX_CONF, 32'h60);
        wait_clk(2 * C);
        check(32'(shutdown_o), 32'h0);
        rdchk(`TCA_IDX_TEMP, 32'h1230);
        // Low lane only; the four lowest limit bits stay zero
        xfer(1'b1, `TCA_IDX_TOS, 32'hAB2F, 4'h1);
        rdchk(`TCA_IDX_TOS, 32'h5020);
        // Pointer picks the window; a pointer with upper bits set is dropped
        wr(`TCA_IDX_PTR, 32'h3);
        wr(`TCA_IDX_PTR, 32'h5);
        rdchk(`TCA_IDX_PTR, 32'h3);
        wr(`TCA_IDX_DATA, 32'h5000);
        rdchk(`TCA_IDX_TOS, 32'h5000);
        rdchk(`TCA_IDX_DATA, 32'h5000);
        rdchk(`TCA_IDX_STAT, 32'h80);
        $display("shutdown and limits done");
        // Comparator mode, every fault count, with a broken run first
        for (int f = 0; f < 4; f++) begin
            temp_code <= 12'h4A0;
            wr(`TCA_IDX_CONF, 32'(f << 3));
            wait_clk(2 * C);
            temp_code <= 12'h510;
            wait_clk((ft[f] - 1) * C);
            temp_code <= 12'h4C0;
            wait_clk(C + 2);
            check(32'(alarm_pin), 32'h1);
            temp_code <= 12'h510;
            n = 0;
            while (alarm_pin !== 1'b0 && n < 7 * C) begin
                @(posedge clk);
                n++;
            end
            check(32'(n > (ft[f] - 1) * C && n <= ft[f] * C + 2), 32'h1);
            if (n >= 7 * C) begin
                finish_test();
            end
            temp_code <= 12'h4C0;
            wait_clk(2 * C);
            check(32'(alarm_pin), 32'h0);
            temp_code <= 12'h4A0;
            wait_clk(C + 2);
            check(32'(alarm_pin), 32'h1);
        end
        $display("comparator done");
        // Active high: idle pin is pulled low, alarm releases it
        wr(`TCA_IDX_CONF, 32'h04);
        wait_clk(2);
        check(32'(alarm_pin), 32'h0);
        temp_code <= 12'h510;
        wait_clk(2 * C);
        check(32'(alarm_pin), 32'h1);
        // Interrupt mode: a read clears, then the cold side arms, shutdown clears
        temp_code <= 12'h4A0;
        wait_clk(2 * C);
        wr(`TCA_IDX_CONF, 32'h02);
        temp_code <= 12'h510;
        wait_clk(2 * C);
        check(32'(alarm_pin), 32'h0);
        rdchk(`TCA_IDX_TEMP, 32'h5100);
        wait_clk(2 * C);
        check(32'(alarm_pin), 32'h1);
        temp_code <= 12'h4A0;
        wait_clk(2 * C);
        check(32'(alarm_pin), 32'h0);
        wr(`TCA_IDX_CONF, 32'h03);
        wait_clk(2);
        check(32'(alarm_pin), 32'h1);
        $display("polarity and interrupt done");
        finish_test();
    end
endmodule : tca_top_bench
